// ===== hw/seq_defs.vh
// constants for the output step sequencer
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

`define CLK_KHZ 50000
`define TICK_MS 100
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)
`define BLINK_PERIOD_MS 500
`define BLINK_HALF_CYCLES ((`BLINK_PERIOD_MS / 2) * `CLK_KHZ)
`define COMP_PERIOD_MS 200
`define COMP_PERIOD_TICKS (`COMP_PERIOD_MS / `TICK_MS)
`define LOCKOUT_MS 1000
`define LOCKOUT_TICKS 4'hA

`define A_STARTUP 8'h01
`define A_ON_DELAY 8'h07
`define A_OFF_DELAY 8'h08
`define A_COMP_MODE 8'h0C
`define A_BEEP_KEY 8'h5A
`define A_BEEP_OTHER 8'h5B
`define A_SEQ_MODE 8'h64
`define A_REPEAT 8'h65
`define A_END_STATE 8'h66
`define A_STEP_FIRST 8'h6E
`define A_STEP_LAST 8'h9F
`define A_V_SET 8'hC8
`define A_I_SET 8'hC9
`define A_STATUS 8'hD2
`define A_CUR_STEP 8'hD3
`define A_EL_MIN 8'hD4
`define A_EL_TENTH 8'hD5
`define A_CUR_REP 8'hD6

`define F_VPRE 3'h0
`define F_IPRE 3'h1
`define F_ACT 3'h2
`define F_MIN 3'h3
`define F_TENTH 3'h4
`define FIELDS 4'h5
`define NSTEPS 4'hA

`define COMP_OFF 2'h0
`define COMP_ONCE 2'h1
`define COMP_CONT 2'h2
`define ACT_OFF 2'h0
`define ACT_JUMP 2'h1
`define ACT_RAMP 2'h2
`define SEQ_OFF 2'h0
`define SEQ_RESTART 2'h1
`define SEQ_RESUME 2'h2

`define STARTUP_CV_SLEW 4'h3
`define STARTUP_CC_SLEW 4'h7
`define STARTUP_CV_LOW 4'h2
`define STARTUP_CC_LOW 4'h6
`define MIN_MAX 16'h270F
`define TENTH_MAX 16'h0257
`define TENTHS_PER_MIN 23'h000258
`define REPEAT_MAX 16'h270F

`endif

// ===== hw/tick_gen.v
// periodic one-cycle pulse generator
`default_nettype none
module tick_gen #(
  parameter [23:0] CYCLES = 24'h4C4B40
) (
  input wire clk,
  input wire nrst,
  output reg pulse
);
  reg [23:0] cnt_r;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 24'h000000;
      pulse <= 1'b0;
    end
    else if (cnt_r == CYCLES - 24'h000001)
    begin
      cnt_r <= 24'h000000;
      pulse <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 24'h000001;
      pulse <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hw/output_step_sequencer.v
// output step sequencer with settings registers
`include "seq_defs.vh"
`default_nettype none
module output_step_sequencer #(
  parameter [23:0] TICK_CYCLES = `TICK_CYCLES,
  parameter [23:0] BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  input wire clk,
  input wire nrst,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire output_key,
  input wire settings_menu_key,
  input wire current_regulation,
  input wire alarm,
  input wire comp_done,
  output reg comp_req,
  output reg [15:0] v_ref,
  output reg [15:0] i_ref,
  output reg out_en,
  output wire out_led,
  output reg key_beep,
  output reg alarm_beep,
  output wire [3:0] startup_mode,
  output wire [15:0] on_delay,
  output wire [15:0] off_delay
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RUN = 2'h1;
  localparam [1:0] S_PAUSE = 2'h2;

  reg [15:0] steps [0:49];
  reg [3:0] startup_r;
  reg [15:0] on_delay_r, off_delay_r, v_set_r, i_set_r, repeat_r;
  reg [1:0] comp_mode_r, seq_mode_r;
  reg beep_key_r, beep_other_r, end_keep_r;
  reg [1:0] state_r;
  reg [3:0] step_r;
  reg [15:0] el_min_r, el_tenth_r, rep_r;
  reg [22:0] el_tot_r;
  reg [15:0] v0_r, i0_r;
  reg want_on_r, comp_valid_r, comp_busy_r, blink_r, hold_r;
  reg [3:0] lock_r;
  reg [1:0] comp_tick_r;
  reg [2:0] key_s, menu_s, reg_s, alarm_s;
  wire tick, blink_tick;
  integer k;

  // 0.1 s tick and indicator blink base
  tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (.clk(clk), .nrst(nrst), .pulse(tick));
  tick_gen #(.CYCLES(BLINK_HALF_CYCLES)) u_blink (.clk(clk), .nrst(nrst), .pulse(blink_tick));

  function [5:0] fidx;
    input [3:0] s;
    input [2:0] f;
    begin
      fidx = s * 6'h05 + {3'h0, f};
    end
  endfunction

  function [22:0] dur_total;
    input [15:0] mn;
    input [15:0] tn;
    begin
      dur_total = {7'h00, mn} * `TENTHS_PER_MIN + {7'h00, tn};
    end
  endfunction

  function [15:0] interp;
    input [15:0] a;
    input [15:0] b;
    input [22:0] el;
    input [22:0] tot;
    reg [38:0] p;
    reg [38:0] q;
    begin
      p = 39'h0;
      q = 39'h0;
      if (b >= a)
      begin
        p = {23'h0, b - a} * {16'h0, el};
        q = p / {16'h0, tot};
        interp = a + q[15:0];
      end
      else
      begin
        p = {23'h0, a - b} * {16'h0, el};
        q = p / {16'h0, tot};
        interp = a - q[15:0];
      end
    end
  endfunction

  // pin synchronisers; stage 0 feeds stage 1 only
  wire key_press = key_s[1] & ~key_s[2];
  wire menu_open = menu_s[1];
  wire reg_flip = reg_s[1] ^ reg_s[2];
  wire alarm_rise = alarm_s[1] & ~alarm_s[2];
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      key_s <= 3'h0;
      menu_s <= 3'h0;
      reg_s <= 3'h0;
      alarm_s <= 3'h0;
    end
    else
    begin
      key_s <= {key_s[1:0], output_key};
      menu_s <= {menu_s[1:0], settings_menu_key};
      reg_s <= {reg_s[1:0], current_regulation};
      alarm_s <= {alarm_s[1:0], alarm};
    end
  end

  wire seq_en = (seq_mode_r != `SEQ_OFF);
  wire running = (state_r == S_RUN);
  wire [15:0] c_v = steps[fidx(step_r, `F_VPRE)];
  wire [15:0] c_i = steps[fidx(step_r, `F_IPRE)];
  wire [1:0] c_act = steps[fidx(step_r, `F_ACT)][1:0];
  wire [22:0] c_dur = dur_total(steps[fidx(step_r, `F_MIN)], steps[fidx(step_r, `F_TENTH)]);
  wire [3:0] n_step = step_r + 4'h1;
  wire [22:0] n_dur = (n_step == `NSTEPS) ? 23'h0 :
    dur_total(steps[fidx(n_step, `F_MIN)], steps[fidx(n_step, `F_TENTH)]);
  wire [22:0] s0_dur = dur_total(steps[fidx(4'h0, `F_MIN)], steps[fidx(4'h0, `F_TENTH)]);
  wire comp_ok = (comp_mode_r != `COMP_ONCE) | comp_valid_r;

  // targets for the references
  reg [15:0] tgt_v, tgt_i;
  reg want_on;
  always @*
  begin
    tgt_v = v_set_r;
    tgt_i = i_set_r;
    want_on = want_on_r;
    if (hold_r)
    begin
      tgt_v = v_ref;
      tgt_i = i_ref;
    end
    if (running)
    begin
      case (c_act)
        `ACT_OFF:
        begin
          tgt_v = v_ref;
          tgt_i = i_ref;
          want_on = 1'b0;
        end
        `ACT_RAMP:
        begin
          tgt_v = interp(v0_r, c_v, el_tot_r + 23'h1, c_dur);
          tgt_i = interp(i0_r, c_i, el_tot_r + 23'h1, c_dur);
          want_on = 1'b1;
        end
        default:
        begin
          tgt_v = c_v;
          tgt_i = c_i;
          want_on = 1'b1;
        end
      endcase
    end
  end

  // register writes
  wire in_tab = (addr >= `A_STEP_FIRST) && (addr <= `A_STEP_LAST);
  wire [7:0] tab_i = addr - `A_STEP_FIRST;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      startup_r <= 4'h0;
      on_delay_r <= 16'h0000;
      off_delay_r <= 16'h0000;
      comp_mode_r <= `COMP_ONCE;
      beep_key_r <= 1'b1;
      beep_other_r <= 1'b1;
      seq_mode_r <= `SEQ_OFF;
      repeat_r <= 16'h0001;
      end_keep_r <= 1'b0;
      v_set_r <= 16'h0000;
      i_set_r <= 16'h0000;
      for (k = 0; k < 50; k = k + 1)
        steps[k] <= 16'h0000;
    end
    else if (wr)
    begin
      case (addr)
        `A_STARTUP: startup_r <= wdata[3:0];
        `A_ON_DELAY: on_delay_r <= wdata;
        `A_OFF_DELAY: off_delay_r <= wdata;
        `A_COMP_MODE: comp_mode_r <= (wdata[1:0] > `COMP_CONT) ? `COMP_ONCE : wdata[1:0];
        `A_BEEP_KEY: beep_key_r <= wdata[0];
        `A_BEEP_OTHER: beep_other_r <= wdata[0];
        `A_SEQ_MODE: seq_mode_r <= (wdata[1:0] > `SEQ_RESUME) ? `SEQ_OFF : wdata[1:0];
        `A_REPEAT: repeat_r <= (wdata > `REPEAT_MAX) ? `REPEAT_MAX : wdata;
        `A_END_STATE: end_keep_r <= wdata[0];
        `A_V_SET: v_set_r <= wdata;
        `A_I_SET: i_set_r <= wdata;
        default:
        begin
          if (in_tab)
          begin
            if (tab_i % 8'h05 == {5'h0, `F_MIN})
              steps[tab_i[5:0]] <= (wdata > `MIN_MAX) ? `MIN_MAX : wdata;
            else if (tab_i % 8'h05 == {5'h0, `F_TENTH})
              steps[tab_i[5:0]] <= (wdata > `TENTH_MAX) ? `TENTH_MAX : wdata;
            else
              steps[tab_i[5:0]] <= wdata;
          end
        end
      endcase
    end
  end

  // forced settings while sequencing
  assign startup_mode = !seq_en ? startup_r :
    (startup_r == `STARTUP_CV_SLEW) ? `STARTUP_CV_LOW :
    (startup_r == `STARTUP_CC_SLEW) ? `STARTUP_CC_LOW : startup_r;
  assign on_delay = seq_en ? 16'h0000 : on_delay_r;
  assign off_delay = seq_en ? 16'h0000 : off_delay_r;
  assign out_led = running ? blink_r : out_en;

  // register reads, data one cycle later
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 16'h0000;
    else if (rd)
    begin
      case (addr)
        `A_STARTUP: rdata <= {12'h000, startup_mode};
        `A_ON_DELAY: rdata <= on_delay;
        `A_OFF_DELAY: rdata <= off_delay;
        `A_COMP_MODE: rdata <= {14'h0000, comp_mode_r};
        `A_BEEP_KEY: rdata <= {15'h0000, beep_key_r};
        `A_BEEP_OTHER: rdata <= {15'h0000, beep_other_r};
        `A_SEQ_MODE: rdata <= {14'h0000, seq_mode_r};
        `A_REPEAT: rdata <= repeat_r;
        `A_END_STATE: rdata <= {15'h0000, end_keep_r};
        `A_V_SET: rdata <= v_set_r;
        `A_I_SET: rdata <= i_set_r;
        `A_STATUS: rdata <= {10'h000, comp_valid_r, lock_r != 4'h0, out_en, state_r, running};
        `A_CUR_STEP: rdata <= {12'h000, step_r} + 16'h0001;
        `A_EL_MIN: rdata <= el_min_r;
        `A_EL_TENTH: rdata <= el_tenth_r;
        `A_CUR_REP: rdata <= rep_r;
        default: rdata <= in_tab ? steps[tab_i[5:0]] : 16'h0000;
      endcase
    end
    else
      rdata <= 16'h0000;
  end

  // sequencer state, timers, output gate and compensation
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= S_IDLE;
      step_r <= 4'h0;
      el_min_r <= 16'h0000;
      el_tenth_r <= 16'h0000;
      el_tot_r <= 23'h0;
      rep_r <= 16'h0000;
      v0_r <= 16'h0000;
      i0_r <= 16'h0000;
      want_on_r <= 1'b0;
      hold_r <= 1'b0;
      out_en <= 1'b0;
      lock_r <= 4'h0;
      v_ref <= 16'h0000;
      i_ref <= 16'h0000;
      comp_valid_r <= 1'b0;
      comp_busy_r <= 1'b0;
      comp_req <= 1'b0;
      comp_tick_r <= 2'h0;
      blink_r <= 1'b0;
      key_beep <= 1'b0;
      alarm_beep <= 1'b0;
    end
    else
    begin
      key_beep <= key_press & beep_key_r;
      alarm_beep <= alarm_rise & beep_other_r;
      blink_r <= running ? (blink_r ^ blink_tick) : 1'b1;
      // output-on lockout after any off
      if (out_en && !(want_on && comp_ok))
      begin
        out_en <= 1'b0;
        lock_r <= `LOCKOUT_TICKS;
      end
      else
      begin
        if (!out_en && want_on && comp_ok && lock_r == 4'h0)
          out_en <= 1'b1;
        if (tick && lock_r != 4'h0)
          lock_r <= lock_r - 4'h1;
      end
      // references: ramps step one LSB per clock, others jump
      if (comp_ok)
      begin
        if (running && c_act == `ACT_RAMP)
        begin
          if (v_ref < tgt_v)
            v_ref <= v_ref + 16'h0001;
          else if (v_ref > tgt_v)
            v_ref <= v_ref - 16'h0001;
          if (i_ref < tgt_i)
            i_ref <= i_ref + 16'h0001;
          else if (i_ref > tgt_i)
            i_ref <= i_ref - 16'h0001;
        end
        else
        begin
          v_ref <= tgt_v;
          i_ref <= tgt_i;
        end
      end
      // compensation engine handshake
      comp_req <= 1'b0;
      if (tick)
        comp_tick_r <= (comp_tick_r == `COMP_PERIOD_TICKS - 1) ? 2'h0 : comp_tick_r + 2'h1;
      if (comp_busy_r)
      begin
        if (comp_done)
        begin
          comp_busy_r <= 1'b0;
          comp_valid_r <= (comp_mode_r == `COMP_ONCE) & ~reg_flip;
        end
      end
      else if (comp_mode_r == `COMP_ONCE && !comp_valid_r &&
               (want_on || v_ref != tgt_v || i_ref != tgt_i))
      begin
        comp_req <= 1'b1;
        comp_busy_r <= 1'b1;
      end
      else if (comp_mode_r == `COMP_CONT && tick && comp_tick_r == 2'h0)
      begin
        comp_req <= 1'b1;
        comp_busy_r <= 1'b1;
      end
      if ((reg_flip || comp_mode_r != `COMP_ONCE) && !(comp_busy_r && comp_done))
        comp_valid_r <= 1'b0;
      // sequencer
      case (state_r)
        S_IDLE, S_PAUSE:
        begin
          if (key_press && !(lock_r != 4'h0 && !want_on_r))
          begin
            hold_r <= 1'b0;
            if (seq_en && !menu_open && !want_on_r)
            begin
              if (state_r == S_IDLE || seq_mode_r == `SEQ_RESTART || !seq_en)
              begin
                step_r <= 4'h0;
                el_min_r <= 16'h0000;
                el_tenth_r <= 16'h0000;
                el_tot_r <= 23'h0;
                rep_r <= 16'h0001;
                v0_r <= v_ref;
                i0_r <= i_ref;
              end
              if (s0_dur != 23'h0)
                state_r <= S_RUN;
              want_on_r <= 1'b0;
            end
            else if (!seq_en || want_on_r)
              want_on_r <= ~want_on_r;
          end
          else if (!seq_en)
            state_r <= S_IDLE;
        end
        S_RUN:
        begin
          if (!seq_en)
          begin
            state_r <= S_IDLE;
            want_on_r <= 1'b0;
          end
          else if (key_press)
          begin
            state_r <= S_PAUSE;
            want_on_r <= 1'b0;
          end
          else if (tick)
          begin
            if (el_tot_r + 23'h1 >= c_dur)
            begin
              el_min_r <= 16'h0000;
              el_tenth_r <= 16'h0000;
              el_tot_r <= 23'h0;
              v0_r <= v_ref;
              i0_r <= i_ref;
              if (n_dur != 23'h0)
                step_r <= n_step;
              else
              begin
                step_r <= 4'h0;
                if (repeat_r != 16'h0000 && rep_r >= repeat_r)
                begin
                  state_r <= S_IDLE;
                  want_on_r <= end_keep_r & out_en;
                  hold_r <= end_keep_r & out_en;
                end
                else
                  rep_r <= rep_r + 16'h0001;
              end
            end
            else
            begin
              el_tot_r <= el_tot_r + 23'h1;
              if (el_tenth_r == `TENTH_MAX)
              begin
                el_tenth_r <= 16'h0000;
                el_min_r <= el_min_r + 16'h0001;
              end
              else
                el_tenth_r <= el_tenth_r + 16'h0001;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== sim/seq_asserts.sv
// assertion checker for the output step sequencer
`include "seq_defs.vh"
`default_nettype none
module seq_asserts #(
  parameter [23:0] TICK_CYCLES = 24'h00000A
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic output_key,
  input wire logic alarm,
  input wire logic comp_req,
  input wire logic out_en,
  input wire logic key_beep,
  input wire logic alarm_beep,
  input wire logic [3:0] startup_mode,
  input wire logic [15:0] on_delay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] seq_r;
  logic kbe_r;
  logic [15:0] off_cnt_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // shadow of sequence mode, key beep enable, cycles with output off
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seq_r <= 2'h0;
      kbe_r <= 1'b1;
      off_cnt_r <= 16'hFFFF;
    end
    else
    begin
      if (wr && addr == `A_SEQ_MODE)
        seq_r <= (wdata > 16'h0002) ? 2'h0 : wdata[1:0];
      if (wr && addr == `A_BEEP_KEY)
        kbe_r <= wdata[0];
      if (out_en)
        off_cnt_r <= 16'h0000;
      else if (off_cnt_r != 16'hFFFF)
        off_cnt_r <= off_cnt_r + 16'h0001;
    end
  end
  property p_rd_idle;
    !$past(rd) |-> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_rd_seq;
    $past(rd && addr == `A_SEQ_MODE) |-> rdata == {14'h0000, seq_r};
  endproperty
  a_rd_seq: assert property (p_rd_seq) else $error("sequence mode readback");
  property p_delay_zero;
    seq_r != 2'h0 |-> on_delay == 16'h0000;
  endproperty
  a_delay_zero: assert property (p_delay_zero) else $error("on delay not forced");
  property p_startup;
    seq_r != 2'h0 |-> startup_mode != `STARTUP_CV_SLEW && startup_mode != `STARTUP_CC_SLEW;
  endproperty
  a_startup: assert property (p_startup) else $error("slew startup kept");
  property p_kbeep_en;
    key_beep |-> $past(kbe_r);
  endproperty
  a_kbeep_en: assert property (p_kbeep_en) else $error("key beep while disabled");
  property p_kbeep_cause;
    key_beep |-> $past(output_key, 3) || $past(output_key, 4) || $past(output_key, 5);
  endproperty
  a_kbeep_cause: assert property (p_kbeep_cause) else $error("key beep without key");
  property p_abeep_cause;
    alarm_beep |-> $past(alarm, 3) || $past(alarm, 4) || $past(alarm, 5);
  endproperty
  a_abeep_cause: assert property (p_abeep_cause) else $error("alarm beep uncaused");
  property p_comp_pulse;
    comp_req |=> !comp_req;
  endproperty
  a_comp_pulse: assert property (p_comp_pulse) else $error("compensation request long");
  property p_lockout;
    $rose(out_en) |-> off_cnt_r >= 9 * TICK_CYCLES;
  endproperty
  a_lockout: assert property (p_lockout) else $error("output on inside lockout");
  c_key: cover property (key_beep);
  c_comp: cover property (comp_req);
  c_on: cover property ($rose(out_en));
endmodule
`default_nettype wire

// ===== sim/output_step_sequencer_bench.sv
// self-checking bench for the output step sequencer
`include "seq_defs.vh"
`default_nettype none
`define CHK(nm, ex, got) \
  begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module output_step_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [23:0] TICK = 24'h00000A;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic output_key = 1'b0;
  logic settings_menu_key = 1'b0;
  logic current_regulation = 1'b0;
  logic alarm = 1'b0;
  logic comp_done = 1'b0;
  logic [15:0] rdata, v_ref, i_ref, on_delay, off_delay, prev;
  logic comp_req, out_en, out_led, key_beep, alarm_beep;
  logic [3:0] startup_mode;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int kb_n = 0;
  int ab_n = 0;
  int cr_n = 0;
  int k0;
  int led0 = 0;
  output_step_sequencer #(.TICK_CYCLES(TICK), .BLINK_HALF_CYCLES(24'h000019)) DUT (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .output_key(output_key), .settings_menu_key(settings_menu_key),
    .current_regulation(current_regulation),
    .alarm(alarm), .comp_done(comp_done), .comp_req(comp_req), .v_ref(v_ref), .i_ref(i_ref),
    .out_en(out_en), .out_led(out_led), .key_beep(key_beep), .alarm_beep(alarm_beep),
    .startup_mode(startup_mode), .on_delay(on_delay), .off_delay(off_delay));
  always #10 clk = ~clk;
  // pulse counters, compensation engine answering next cycle, timeout
  always @(posedge clk)
  begin
    cyc++;
    kb_n += (key_beep === 1'b1);
    ab_n += (alarm_beep === 1'b1);
    cr_n += (comp_req === 1'b1);
    comp_done <= (comp_req === 1'b1);
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rget(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    rget(a, v);
    `CHK($sformatf("reg %0h", a), e, v & m)
  endtask
  task automatic wchk(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
    wreg(a, d);
    rchk(a, 16'hFFFF, e);
  endtask
  task automatic setstep(input logic [15:0] v, input logic [15:0] act, input logic [15:0] t);
    wreg(`A_STEP_FIRST + `F_VPRE, v);
    wreg(`A_STEP_FIRST + `F_IPRE, 16'h0007);
    wreg(`A_STEP_FIRST + `F_ACT, act);
    wreg(`A_STEP_FIRST + `F_MIN, 16'h0000);
    wreg(`A_STEP_FIRST + `F_TENTH, t);
  endtask
  task automatic press();
    @(posedge clk);
    output_key <= 1'b1;
    repeat (8) @(posedge clk);
    output_key <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_en(input logic v, input int n);
    int k;
    for (k = 0; k < n && out_en !== v; k++)
    begin
      @(posedge clk);
      #1;
    end
    `CHK("out_en", v, out_en)
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rchk(`A_COMP_MODE, 16'hFFFF, 16'h0001);
    rchk(`A_BEEP_KEY, 16'hFFFF, 16'h0001);
    rchk(`A_BEEP_OTHER, 16'hFFFF, 16'h0001);
    rchk(`A_END_STATE, 16'hFFFF, 16'h0000);
    rchk(8'hF0, 16'hFFFF, 16'h0000);
    wchk(`A_STEP_FIRST + `F_MIN, 16'hFFFF, `MIN_MAX);
    wchk(`A_STEP_FIRST + `F_TENTH, 16'hFFFF, `TENTH_MAX);
    wchk(`A_STEP_LAST, 16'h0005, 16'h0005);
    wchk(`A_REPEAT, 16'hFFFF, `REPEAT_MAX);
    wchk(`A_SEQ_MODE, 16'h0003, 16'h0000);
    wchk(`A_COMP_MODE, 16'h0003, 16'h0001);
    wreg(`A_STARTUP, 16'h0003);
    wreg(`A_ON_DELAY, 16'h0005);
    wreg(`A_OFF_DELAY, 16'h0006);
    #1 `CHK("startup", 4'h3, startup_mode)
    `CHK("on delay", 16'h0005, on_delay)
    wreg(`A_SEQ_MODE, 16'h0001);
    #1 `CHK("startup", `STARTUP_CV_LOW, startup_mode)
    `CHK("off delay", 16'h0000, off_delay)
    wreg(`A_STARTUP, 16'h0007);
    #1 `CHK("startup", `STARTUP_CC_LOW, startup_mode)
    // one jump step of three ticks, single pass, output off at end
    wreg(`A_COMP_MODE, 16'h0000);
    wreg(`A_REPEAT, 16'h0001);
    setstep(16'h0005, {14'h0000, `ACT_JUMP}, 16'h0003);
    settings_menu_key <= 1'b1;
    press();
    settings_menu_key <= 1'b0;
    rchk(`A_STATUS, 16'h0009, 16'h0000);
    press();
    `CHK("v_ref", 16'h0005, v_ref)
    `CHK("i_ref", 16'h0007, i_ref)
    `CHK("out_en", 1'b1, out_en)
    rchk(`A_CUR_STEP, 16'hFFFF, 16'h0001);
    rchk(`A_CUR_REP, 16'hFFFF, 16'h0001);
    rchk(`A_STATUS, 16'h0001, 16'h0001);
    wait_en(1'b0, 60);
    rchk(`A_STATUS, 16'h0001, 16'h0000);
    press();
    repeat (20) @(posedge clk);
    `CHK("out_en", 1'b0, out_en)
    repeat (120) @(posedge clk);
    // plain output with compensation once, then continuous
    wreg(`A_SEQ_MODE, 16'h0000);
    wreg(`A_COMP_MODE, 16'h0001);
    k0 = cr_n;
    press();
    wait_en(1'b1, 20);
    `CHK("once requests", k0 + 1, cr_n)
    `CHK("key beeps", 4, kb_n)
    current_regulation <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK("flip requests", k0 + 2, cr_n)
    wreg(`A_COMP_MODE, 16'h0002);
    repeat (10) @(posedge clk);
    #1 k0 = cr_n;
    repeat (100) @(posedge clk);
    #1 `CHK("periodic requests", k0 + 5, cr_n)
    wreg(`A_COMP_MODE, 16'h0000);
    press();
    wait_en(1'b0, 20);
    repeat (120) @(posedge clk);
    // ramp from zero to 20 over five ticks, output kept at end, indicator blinks meanwhile
    wreg(`A_SEQ_MODE, 16'h0001);
    wreg(`A_END_STATE, 16'h0001);
    setstep(16'h0014, {14'h0000, `ACT_RAMP}, 16'h0005);
    press();
    #1;
    repeat (80)
    begin
      prev = v_ref;
      @(posedge clk);
      #1 `CHK("ramp stair", 1'b1, v_ref >= prev && v_ref - prev <= 16'h0001)
      led0 += (out_led === 1'b0);
    end
    `CHK("ramp end", 16'h0014, v_ref)
    `CHK("kept on", 1'b1, out_en)
    `CHK("led blink", 1'b1, led0 != 0)
    `CHK("led steady", 1'b1, out_led)
    // beep enables
    wreg(`A_BEEP_KEY, 16'h0000);
    k0 = kb_n;
    press();
    `CHK("muted key beeps", k0, kb_n)
    for (int j = 1; j >= 0; j--)
    begin
      wreg(`A_BEEP_OTHER, j[15:0]);
      k0 = ab_n;
      @(posedge clk);
      alarm <= 1'b1;
      repeat (8) @(posedge clk);
      alarm <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK("alarm beeps", k0 + j, ab_n)
    end
    // resume mode: elapsed time frozen in pause, run finishes only the remainder
    wreg(`A_END_STATE, 16'h0000);
    wreg(`A_SEQ_MODE, 16'h0002);
    setstep(16'h0009, {14'h0000, `ACT_JUMP}, 16'h000A);
    repeat (120) @(posedge clk);
    press();
    repeat (30) @(posedge clk);
    press();
    rget(`A_EL_TENTH, prev);
    repeat (120) @(posedge clk);
    rchk(`A_EL_TENTH, 16'hFFFF, prev);
    rchk(`A_EL_MIN, 16'hFFFF, 16'h0000);
    rchk(`A_STATUS, 16'h0007, 16'h0004);
    press();
    `CHK("resumed", 1'b1, out_en)
    wait_en(1'b0, 10 * (10 - prev));
    // output-off step runs with the output held off
    setstep(16'h0005, {14'h0000, `ACT_OFF}, 16'h0003);
    repeat (120) @(posedge clk);
    press();
    rchk(`A_STATUS, 16'h0009, 16'h0001);
    print_verdict();
  end
endmodule
bind output_step_sequencer seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .output_key(output_key), .alarm(alarm), .comp_req(comp_req), .out_en(out_en),
  .key_beep(key_beep), .alarm_beep(alarm_beep), .startup_mode(startup_mode),
  .on_delay(on_delay));
`default_nettype wire
